// ---- core/oneshot_pkg.sv ----
// package for the one-shot reload timer: register map, field positions, states
// assumes a 32-bit APB register bus, one clock at 20 MHz
package oneshot_pkg;
    // ==============================
    // register byte offsets
    localparam logic [7:0] ctrl_addr = 8'h00;
    localparam logic [7:0] oneshot_addr = 8'h04;
    localparam logic [7:0] irq_addr = 8'h08;
    localparam logic [7:0] mode_addr = 8'h0c;
    localparam logic [7:0] prescale_addr = 8'h10;
    localparam logic [7:0] primary_addr = 8'h14;
    localparam logic [7:0] stat_addr = 8'h18;
    localparam logic [7:0] stat_clr_addr = 8'h1c;
    localparam logic [7:0] stat_en_addr = 8'h20;
    // ==============================
    // field positions
    localparam int start_pos = 0;
    localparam int running_pos = 1;
    localparam int stop_pos = 2;
    localparam int pulse_start_pos = 0;
    localparam int pulse_active_pos = 2;
    localparam int irq_req_pos = 6;
    localparam int irq_en_pos = 7;
    localparam int mode_lo_pos = 0;
    localparam int mode_hi_pos = 1;
    localparam int cnt16_pos = 2;
    localparam logic [1:0] mode_oneshot = 2'h2;
    localparam logic [7:0] reload_reset = 8'hff;
    localparam int n_events = 2;
    localparam int ev_underflow = 0;
    localparam int ev_pulse_start = 1;
    // ==============================
    typedef enum logic [1:0] {st_idle, st_wait, st_pulse} shot_e;
    typedef struct packed {
        logic start;
        logic stop;
        logic shot;
    } strobes_s;
endpackage

// ---- core/oneshot_timer.sv ----
// one-shot reload timer control, status, counter and interrupt over APB
// assumes count_tick is a one-cycle pulse synchronous to pclk
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [R1] A read-only flag reports whether the count is stopped or running.
// [R2] A read-only flag reports the one-shot as operating from trigger through wait and pulse.
// [R3] Writing 1 to the one-shot start bit starts the one-shot count and the bit reads 0.
// [R4] Software polls the one-shot flag until stopped before issuing a new start.
// [R5] The request flag is read and write, and writing 0 clears it to no request.
// [R6] Writing 1 to the count start bit enables counting and the running flag follows.
// [R7] Writing 1 to the forced-stop bit halts the count at once and the bit reads 0.
// [R8] The two-bit mode field at binary 10 selects one-shot generation mode.
// [R9] In 8-bit mode the primary counter steps on prescaler underflow, the prescaler on ticks.
// [R10] At the pulse end the request flag sets, the output goes inactive, the one-shot flag clears.
module oneshot_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic count_tick,
    output logic pulse_output_pin,
    output logic underflow_pulse,
    output logic irq
);
    // ==============================
    // bus decode
    logic wr, rd;
    oneshot_pkg::strobes_s stb;
    assign pready = 1'b1;
    assign wr = psel & penable & pwrite & clk_en;
    assign rd = psel & penable & ~pwrite;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = hit(a, oneshot_pkg::ctrl_addr) | hit(a, oneshot_pkg::oneshot_addr)
            | hit(a, oneshot_pkg::irq_addr) | hit(a, oneshot_pkg::mode_addr)
            | hit(a, oneshot_pkg::prescale_addr) | hit(a, oneshot_pkg::primary_addr)
            | hit(a, oneshot_pkg::stat_addr) | hit(a, oneshot_pkg::stat_clr_addr)
            | hit(a, oneshot_pkg::stat_en_addr);
    endfunction

    assign pslverr = psel & penable & ~mapped(paddr);
    assign stb.start = wr & hit(paddr, oneshot_pkg::ctrl_addr) & pwdata[oneshot_pkg::start_pos];
    assign stb.stop = wr & hit(paddr, oneshot_pkg::ctrl_addr) & pwdata[oneshot_pkg::stop_pos];
    assign stb.shot = wr & hit(paddr, oneshot_pkg::oneshot_addr)
        & pwdata[oneshot_pkg::pulse_start_pos];

    // ==============================
    // state
    logic run_en_q, run_en_d, irq_req_q, irq_req_d, irq_en_q, irq_en_d;
    logic cnt16_q, cnt16_d, out_q, out_d, ufl_q, ufl_d;
    logic [1:0] mode_q, mode_d;
    logic [7:0] pre_rel_q, pre_rel_d, pri_rel_q, pri_rel_d;
    logic [7:0] pre_q, pre_d, pri_q, pri_d;
    logic [1:0] stat_q, stat_d, sten_q, sten_d;
    logic [31:0] rdata_d;
    oneshot_pkg::shot_e shot_q, shot_d;
    logic oneshot_mode, running, pre_uf, pri_uf, pulse_end, shot_go;
    logic [15:0] cnt16_val;
    logic [1:0] ev;

    assign oneshot_mode = (mode_q == oneshot_pkg::mode_oneshot); // R8
    assign running = run_en_q; // R1
    assign shot_go = stb.shot & run_en_q & oneshot_mode & (shot_q == oneshot_pkg::st_idle); // R3
    // 16-bit mode: primary is the high byte, prescaler the low byte
    assign cnt16_val = {pri_q, pre_q};
    // 8-bit: prescaler steps down on each tick and reloads on its underflow, primary steps on that underflow
    assign pre_uf = count_tick & (pre_q == 8'h00); // R9
    assign pri_uf = cnt16_q ? (count_tick & (cnt16_val == 16'h0000))
        : (pre_uf & (pri_q == 8'h00)); // R9
    // a forced stop in the final tick wins: no underflow event, no request
    assign pulse_end = (shot_q == oneshot_pkg::st_pulse) & pri_uf & ~stb.stop;
    assign ev[oneshot_pkg::ev_underflow] = pulse_end;
    assign ev[oneshot_pkg::ev_pulse_start] = shot_go;

    always_comb begin
        run_en_d = run_en_q;
        mode_d = mode_q;
        cnt16_d = cnt16_q;
        pre_rel_d = pre_rel_q;
        pri_rel_d = pri_rel_q;
        irq_en_d = irq_en_q;
        irq_req_d = irq_req_q;
        sten_d = sten_q;
        pre_d = pre_q;
        pri_d = pri_q;
        shot_d = shot_q;
        out_d = out_q;
        ufl_d = 1'b0;
        if (stb.start) begin
            run_en_d = 1'b1; // R6
        end
        if (wr & hit(paddr, oneshot_pkg::ctrl_addr) & ~pwdata[oneshot_pkg::start_pos]) begin
            run_en_d = 1'b0;
        end
        if (stb.stop) begin
            run_en_d = 1'b0; // R7
        end
        if (wr & hit(paddr, oneshot_pkg::mode_addr)) begin
            mode_d = pwdata[oneshot_pkg::mode_hi_pos:oneshot_pkg::mode_lo_pos];
            cnt16_d = pwdata[oneshot_pkg::cnt16_pos];
        end
        if (wr & hit(paddr, oneshot_pkg::prescale_addr)) begin
            pre_rel_d = pwdata[7:0];
        end
        if (wr & hit(paddr, oneshot_pkg::primary_addr)) begin
            pri_rel_d = pwdata[7:0];
        end
        if (wr & hit(paddr, oneshot_pkg::irq_addr)) begin
            irq_en_d = pwdata[oneshot_pkg::irq_en_pos];
            if (!pwdata[oneshot_pkg::irq_req_pos]) begin
                irq_req_d = 1'b0; // R5
            end
        end
        if (wr & hit(paddr, oneshot_pkg::stat_en_addr)) begin
            sten_d = pwdata[1:0];
        end
        // one-shot sequencer; a trigger waits one cycle while counters reload
        case (shot_q)
            oneshot_pkg::st_idle: begin
                if (shot_go) begin
                    shot_d = oneshot_pkg::st_wait; // R2
                    pre_d = pre_rel_q;
                    pri_d = pri_rel_q;
                end
            end
            oneshot_pkg::st_wait: begin
                shot_d = oneshot_pkg::st_pulse;
                out_d = 1'b1;
            end
            oneshot_pkg::st_pulse: begin
                if (count_tick) begin
                    // as the low byte of the 16-bit count the prescaler borrows through ff
                    if (cnt16_q) begin
                        pre_d = pre_q - 8'h01;
                    end else begin
                        pre_d = pre_uf ? pre_rel_q : pre_q - 8'h01; // R9
                    end
                    if (cnt16_q) begin
                        pri_d = (pre_q == 8'h00) ? pri_q - 8'h01 : pri_q;
                    end else if (pre_uf) begin
                        pri_d = pri_q - 8'h01; // R9
                    end
                end
                if (pulse_end) begin
                    shot_d = oneshot_pkg::st_idle; // R10
                    out_d = 1'b0; // R10
                    ufl_d = 1'b1;
                    irq_req_d = 1'b1; // R10
                end
            end
            default: begin
                shot_d = oneshot_pkg::st_idle;
            end
        endcase
        // forced stop aborts the shot, output back to inactive
        if (stb.stop | ~run_en_q) begin
            shot_d = oneshot_pkg::st_idle; // R7
            out_d = 1'b0;
        end
    end

    // sticky status: set wins over the clear written the same cycle
    always_comb begin
        stat_d = stat_q;
        if (wr & hit(paddr, oneshot_pkg::stat_clr_addr)) begin
            stat_d = stat_q & ~pwdata[1:0];
        end
        stat_d = stat_d | ev;
    end

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (rd) begin
            case (paddr)
                oneshot_pkg::ctrl_addr: rdata_d[oneshot_pkg::running_pos] = running; // R1 R7
                oneshot_pkg::oneshot_addr: begin
                    rdata_d[oneshot_pkg::pulse_active_pos] =
                        (shot_q != oneshot_pkg::st_idle); // R2 R3
                end
                oneshot_pkg::irq_addr: begin
                    rdata_d[oneshot_pkg::irq_req_pos] = irq_req_q; // R5
                    rdata_d[oneshot_pkg::irq_en_pos] = irq_en_q;
                end
                oneshot_pkg::mode_addr: rdata_d[2:0] = {cnt16_q, mode_q};
                oneshot_pkg::prescale_addr: rdata_d[7:0] = pre_rel_q;
                oneshot_pkg::primary_addr: rdata_d[7:0] = pri_rel_q;
                oneshot_pkg::stat_addr: rdata_d[1:0] = stat_q;
                oneshot_pkg::stat_en_addr: rdata_d[1:0] = sten_q;
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // read data is combinational from current state so it is valid in the access cycle
    assign prdata = rdata_d;
    assign pulse_output_pin = out_q;
    assign underflow_pulse = ufl_q;
    assign irq = (|(stat_q & sten_q)) | (irq_req_q & irq_en_q);

    // ==============================
    // registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_en_q <= 1'b0;
            mode_q <= 2'h0;
            cnt16_q <= 1'b0;
            pre_rel_q <= oneshot_pkg::reload_reset;
            pri_rel_q <= oneshot_pkg::reload_reset;
            irq_en_q <= 1'b0;
            irq_req_q <= 1'b0;
            sten_q <= 2'h0;
            stat_q <= 2'h0;
            pre_q <= oneshot_pkg::reload_reset;
            pri_q <= oneshot_pkg::reload_reset;
            shot_q <= oneshot_pkg::st_idle;
            out_q <= 1'b0;
            ufl_q <= 1'b0;
        end else if (clk_en) begin
            run_en_q <= run_en_d;
            mode_q <= mode_d;
            cnt16_q <= cnt16_d;
            pre_rel_q <= pre_rel_d;
            pri_rel_q <= pri_rel_d;
            irq_en_q <= irq_en_d;
            irq_req_q <= irq_req_d;
            sten_q <= sten_d;
            stat_q <= stat_d;
            pre_q <= pre_d;
            pri_q <= pri_d;
            shot_q <= shot_d;
            out_q <= out_d;
            ufl_q <= ufl_d;
        end
    end

    // ==============================
    // checks
    a_start_sets_run: assert property (@(posedge pclk) disable iff (!presetn) // R6
        (stb.start & ~stb.stop & clk_en) |=> running) else $error("start lost");
    a_stop_halts: assert property (@(posedge pclk) disable iff (!presetn) // R7
        (stb.stop & clk_en) |=> (~running & (shot_q == oneshot_pkg::st_idle)))
        else $error("stop ignored");
    a_shot_enters_wait: assert property (@(posedge pclk) disable iff (!presetn) // R3
        (shot_go & clk_en) |=> (shot_q == oneshot_pkg::st_wait)) else $error("no shot");
    a_shot_needs_mode: assert property (@(posedge pclk) disable iff (!presetn) // R8
        ($rose(shot_q == oneshot_pkg::st_wait)) |-> $past(oneshot_mode))
        else $error("shot outside mode");
    a_end_sets_req: assert property (@(posedge pclk) disable iff (!presetn) // R10
        (pulse_end & clk_en) |=> (irq_req_q & ~pulse_output_pin
        & (shot_q == oneshot_pkg::st_idle))) else $error("pulse end wrong");
    a_clear_req: assert property (@(posedge pclk) disable iff (!presetn) // R5
        (wr & hit(paddr, oneshot_pkg::irq_addr) & ~pwdata[oneshot_pkg::irq_req_pos]
        & ~pulse_end) |=> ~irq_req_q) else $error("clear failed");
    a_out_in_pulse: assert property (@(posedge pclk) disable iff (!presetn) // R2
        pulse_output_pin |-> (shot_q == oneshot_pkg::st_pulse)) else $error("stray out");
    a_pre_reload: assert property (@(posedge pclk) disable iff (!presetn) // R9
        (clk_en & ~cnt16_q & pre_uf & (shot_q == oneshot_pkg::st_pulse) & ~pulse_end
        & ~stb.stop & run_en_q) |=> (pre_q == $past(pre_rel_q)
        && pri_q == $past(pri_q) - 8'h01)) else $error("prescale chain");
    a_start_reads_zero: assert property (@(posedge pclk) disable iff (!presetn) // R3
        (rd & hit(paddr, oneshot_pkg::oneshot_addr)) |-> ~prdata[oneshot_pkg::pulse_start_pos])
        else $error("start bit read");
    // ==============================
    // read-back, sequencing, chain, decode and freeze checks
    a_stop_reads_zero: assert property (@(posedge pclk) disable iff (!presetn) // R7
        (rd & hit(paddr, oneshot_pkg::ctrl_addr)) |-> ~prdata[oneshot_pkg::stop_pos])
        else $error("stop bit read");
    a_zero_write_stops: assert property (@(posedge pclk) disable iff (!presetn) // R1
        (wr & hit(paddr, oneshot_pkg::ctrl_addr) & ~pwdata[oneshot_pkg::start_pos])
        |=> ~running) else $error("count kept running");
    a_wait_to_pulse: assert property (@(posedge pclk) disable iff (!presetn) // R2
        ((shot_q == oneshot_pkg::st_wait) & clk_en & ~stb.stop & run_en_q)
        |=> ((shot_q == oneshot_pkg::st_pulse) & pulse_output_pin)) else $error("wait stuck");
    a_flag_holds: assert property (@(posedge pclk) disable iff (!presetn) // R2
        ((shot_q != oneshot_pkg::st_idle) & clk_en & ~pulse_end & ~stb.stop & run_en_q)
        |=> (shot_q != oneshot_pkg::st_idle)) else $error("one-shot dropped early");
    a_wide_borrow: assert property (@(posedge pclk) disable iff (!presetn) // R9
        (clk_en & cnt16_q & pre_uf & (shot_q == oneshot_pkg::st_pulse) & ~pulse_end
        & ~stb.stop & run_en_q) |=> (pre_q == 8'hff && pri_q == $past(pri_q) - 8'h01))
        else $error("16-bit chain");
    a_ufl_single: assert property (@(posedge pclk) disable iff (!presetn) // R10
        (underflow_pulse & clk_en) |=> ~underflow_pulse) else $error("long underflow");
    a_ufl_flags: assert property (@(posedge pclk) disable iff (!presetn) // R10
        underflow_pulse |-> (irq_req_q & stat_q[oneshot_pkg::ev_underflow]))
        else $error("underflow without flags");
    a_start_event: assert property (@(posedge pclk) disable iff (!presetn)
        (shot_go & clk_en) |=> stat_q[oneshot_pkg::ev_pulse_start]) else $error("no start event");
    a_unmapped_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (rd & ~mapped(paddr)) |-> (pslverr && prdata == 32'h0000_0000))
        else $error("unmapped read data");
    a_freeze_state: assert property (@(posedge pclk) disable iff (!presetn)
        ~clk_en |=> ($stable(shot_q) && $stable(run_en_q) && $stable(irq_req_q)
        && $stable(stat_q) && $stable(pre_rel_q))) else $error("state moved while frozen");
endmodule
`default_nettype wire

// ---- testbench/oneshot_timer_bench.sv ----
// self-checking bench for the one-shot timer: apb register walk, pulse timing, interrupts
// assumes the design answers with pready and drives prdata during the access phase
`timescale 1ns/1ps
`default_nettype none
module oneshot_timer_bench;
    logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, count_tick = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h0000b1bd;
    logic pready, pslverr, pulse_output_pin, underflow_pulse, irq;
    int num_errors = 0, num_checks = 0, n_under = 0, pre, pri, len, k, m_stat;
    int q_len[$];
    oneshot_timer i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .count_tick(count_tick),
        .pulse_output_pin(pulse_output_pin), .underflow_pulse(underflow_pulse), .irq(irq));
    initial forever #25 pclk = ~pclk;
    always @(posedge pclk) if (underflow_pulse === 1'b1) n_under++;
    // ==============================
    // helpers
    function automatic logic [31:0] xs();
        logic [31:0] s;
        s = seed;
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        seed = s;
        return s;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // no cap of its own on the wait: a slave that never answers is caught by the watchdog
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic tick();
        @(posedge pclk) count_tick <= 1'b1;
        @(posedge pclk) count_tick <= 1'b0;
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ==============================
    // watchdog sized well above the whole sequence
    initial begin
        #(50 * 20000);
        num_errors++;
        end_of_test();
    end
    // ==============================
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(oneshot_pkg::ctrl_addr, 32'h0);
        rdchk(oneshot_pkg::oneshot_addr, 32'h0);
        rdchk(oneshot_pkg::irq_addr, 32'h0);
        apb(1'b0, 8'h24, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, oneshot_pkg::mode_addr, 32'h2);
        apb(1'b1, oneshot_pkg::irq_addr, 32'h80);
        // start while stopped must be ignored
        apb(1'b1, oneshot_pkg::oneshot_addr, 32'h1);
        rdchk(oneshot_pkg::oneshot_addr, 32'h0);
        apb(1'b1, oneshot_pkg::ctrl_addr, 32'h1);
        apb(1'b0, oneshot_pkg::ctrl_addr, 32'h0);
        chk(rd & 32'hfffffffe, 32'h2);
        for (k = 0; k < 2; k++) begin
            pre = int'(xs() % 3);
            pri = int'(xs() % 3);
            apb(1'b1, oneshot_pkg::prescale_addr, 32'(pre));
            apb(1'b1, oneshot_pkg::primary_addr, 32'(pri));
            repeat (10) begin
                apb(1'b0, oneshot_pkg::oneshot_addr, 32'h0);
                if (rd[2] === 1'b0) break;
            end
            apb(1'b1, oneshot_pkg::oneshot_addr, 32'h1);
            q_len.push_back((pre + 1) * (pri + 1));
            repeat (3) @(posedge pclk);
            chk({31'h0, pulse_output_pin}, 32'h1);
            rdchk(oneshot_pkg::oneshot_addr, 32'h4);
            len = q_len.pop_front();
            repeat (len - 1) tick();
            chk({31'h0, pulse_output_pin}, 32'h1);
            rdchk(oneshot_pkg::irq_addr, 32'h80);
            tick();
            repeat (3) @(posedge pclk);
            chk({31'h0, pulse_output_pin}, 32'h0);
            chk(32'(n_under), 32'(k + 1));
            chk({31'h0, irq}, 32'h1);
            rdchk(oneshot_pkg::oneshot_addr, 32'h0);
            rdchk(oneshot_pkg::irq_addr, 32'hc0);
            apb(1'b1, oneshot_pkg::irq_addr, 32'h80);
            @(posedge pclk);
            chk({31'h0, irq}, 32'h0);
            rdchk(oneshot_pkg::irq_addr, 32'h80);
        end
        // 16-bit chain: {primary, prescale} counts down and ends one tick after zero
        apb(1'b1, oneshot_pkg::mode_addr, 32'h6);
        apb(1'b1, oneshot_pkg::prescale_addr, 32'h1);
        apb(1'b1, oneshot_pkg::primary_addr, 32'h1);
        apb(1'b1, oneshot_pkg::oneshot_addr, 32'h1);
        q_len.push_back(1 * 256 + 1 + 1);
        len = q_len.pop_front();
        repeat (len - 1) tick();
        chk({31'h0, pulse_output_pin}, 32'h1);
        tick();
        repeat (3) @(posedge pclk);
        chk({31'h0, pulse_output_pin}, 32'h0);
        chk(32'(n_under), 32'h3);
        apb(1'b1, oneshot_pkg::irq_addr, 32'h80);
        // forced stop in mid-pulse: output drops, no underflow, no request
        rdchk(oneshot_pkg::oneshot_addr, 32'h0);
        apb(1'b1, oneshot_pkg::oneshot_addr, 32'h1);
        repeat (4) tick();
        apb(1'b1, oneshot_pkg::ctrl_addr, 32'h4);
        @(posedge pclk);
        chk({31'h0, pulse_output_pin}, 32'h0);
        rdchk(oneshot_pkg::oneshot_addr, 32'h0);
        rdchk(oneshot_pkg::irq_addr, 32'h80);
        chk(32'(n_under), 32'h3);
        // writing 0 to the start bit stops the count as well
        apb(1'b1, oneshot_pkg::ctrl_addr, 32'h1);
        apb(1'b1, oneshot_pkg::ctrl_addr, 32'h0);
        rdchk(oneshot_pkg::ctrl_addr, 32'h0);
        // with clock enable low the write is dropped
        clk_en <= 1'b0;
        apb(1'b1, oneshot_pkg::prescale_addr, 32'h55);
        clk_en <= 1'b1;
        rdchk(oneshot_pkg::prescale_addr, 32'h1);
        // sticky status: write to the read-only copy is dropped
        m_stat = 3;
        apb(1'b1, oneshot_pkg::stat_addr, 32'h0);
        rdchk(oneshot_pkg::stat_addr, 32'(m_stat));
        apb(1'b1, oneshot_pkg::stat_en_addr, 32'h1);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, oneshot_pkg::stat_clr_addr, 32'h1);
        m_stat = 2;
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        rdchk(oneshot_pkg::stat_addr, 32'(m_stat));
        apb(1'b1, oneshot_pkg::ctrl_addr, 32'h4);
        apb(1'b0, oneshot_pkg::ctrl_addr, 32'h0);
        chk(rd & 32'h6, 32'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
